// [core/pdt_timer.sv]
// dual 8-bit presettable down timer with prescalers, event and pulse width modes
// assumes all inputs synchronous to core_clk_i, oscillator inputs much slower than it
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module pdt_timer (
    input  wire logic                      core_clk_i,               // core clock, 10 MHz
    input  wire logic                      rst_n_i,                  // sync reset, active low
    input  wire logic [pdt_pkg::ADDR_W-1:0] addr_i,                  // register address
    input  wire logic [pdt_pkg::DATA_W-1:0] wr_data_i,               // write data
    input  wire logic                      wr_en_i,                  // write strobe
    input  wire logic                      rd_en_i,                  // read strobe
    input  wire logic                      slow_oscillator_i,        // slow source clock level
    input  wire logic                      fast_oscillator_i,        // fast source clock level
    input  wire logic                      noise_ref_i,              // 2,048 Hz reference level
    input  wire logic                      event_input_pin_i,        // external event input
    output logic      [pdt_pkg::DATA_W-1:0] rd_data_o,               // read data, cycle after
    output logic                           underflow_flag_t0_o,      // timer 0 underflow pulse
    output logic                           underflow_flag_t1_o,      // timer 1 underflow pulse
    output logic                           clock_out_pin_o,          // halved underflow clock
    output logic                           inverted_clock_out_pin_o  // inverted clock output
);

    // software visible state
    pdt_pkg::pdt_ctrl_s          ctrl [2];     // per-timer control
    pdt_pkg::pdt_mode_s          mode;         // shared mode bits
    logic [pdt_pkg::CNT_W-1:0]   reload [2];   // reload values
    logic [pdt_pkg::CNT_W-1:0]   cnt [2];      // down counters
    logic [pdt_pkg::PRE_W-1:0]   pre [2];      // prescaler counters

    // edge history of the slow inputs, noise rejecter and clock out state
    logic                        slow_prev;    // slow oscillator last cycle
    logic                        fast_prev;    // fast oscillator last cycle
    logic                        ref_prev;     // reference last cycle
    logic                        ev_prev;      // event level last cycle
    logic                        filt;         // noise rejected event level
    logic [1:0]                  nr_cnt;       // reference falling edges seen
    logic                        halved_underflow_out;         // halved underflow clock

    // address decode
    wire wr_ctrl0  = wr_en_i && (addr_i == pdt_pkg::OFF_CTRL_T0);
    wire wr_ctrl1  = wr_en_i && (addr_i == pdt_pkg::OFF_CTRL_T1);
    wire wr_mode   = wr_en_i && (addr_i == pdt_pkg::OFF_MODE);
    wire wr_rld0   = wr_en_i && (addr_i == pdt_pkg::OFF_RELOAD_T0);
    wire wr_rld1   = wr_en_i && (addr_i == pdt_pkg::OFF_RELOAD_T1);

    // mode shorthand
    wire width     = mode.width_select;
    wire ev_mode   = mode.counter_mode_select;
    wire pol       = mode.input_polarity_select;
    wire func      = mode.function_select;

    // preset strobes; timer 1 strobe is dead in 16-bit mode
    wire preset0   = wr_ctrl0 && wr_data_i[pdt_pkg::B_PRESET];
    wire preset1   = wr_ctrl1 && wr_data_i[pdt_pkg::B_PRESET] && !width;

    // oscillator rising edges serve as source ticks
    wire slow_rise = slow_oscillator_i && !slow_prev;
    wire fast_rise = fast_oscillator_i && !fast_prev;
    wire ref_fall  = !noise_ref_i && ref_prev;

    // effective per-prescaler settings; 16-bit mode borrows timer 0 controls
    wire       run_eff0 = ctrl[0].run;
    wire       run_eff1 = width ? ctrl[0].run : ctrl[1].run;
    wire       src_sel1 = width ? ctrl[0].source_sel : ctrl[1].source_sel;
    wire [1:0] ratio1   = width ? ctrl[0].ratio : ctrl[1].ratio;
    wire       src_tick0 = ctrl[0].source_sel ? fast_rise : slow_rise;
    wire       src_tick1 = src_sel1 ? fast_rise : slow_rise;

    // source ticks pass into a prescaler only while its timer runs
    wire feed0 = run_eff0 && src_tick0;
    wire feed1 = run_eff1 && src_tick1;

    // ratio code to terminal mask
    function automatic logic [pdt_pkg::PRE_W-1:0] ratio_mask(input logic [1:0] code);
        unique case (code)
            2'b00:   ratio_mask = pdt_pkg::PRE_MASK_1;
            2'b01:   ratio_mask = pdt_pkg::PRE_MASK_4;
            2'b10:   ratio_mask = pdt_pkg::PRE_MASK_16;
            2'b11:   ratio_mask = pdt_pkg::PRE_MASK_64;
        endcase
    endfunction

    wire [pdt_pkg::PRE_W-1:0] mask0 = ratio_mask(ctrl[0].ratio);
    wire [pdt_pkg::PRE_W-1:0] mask1 = ratio_mask(ratio1);

    // prescaler output: one tick per 1, 4, 16 or 64 fed source ticks
    wire pre_tick0 = feed0 && ((pre[0] & mask0) == mask0);
    wire pre_tick1 = feed1 && ((pre[1] & mask1) == mask1);

    // event level: raw pin or the noise rejected copy
    wire ev_level  = func ? filt : event_input_pin_i;
    wire ev_rise   = ev_level && !ev_prev;
    wire ev_fall   = !ev_level && ev_prev;
    wire ev_edge   = pol ? ev_rise : ev_fall;
    wire lvl_ok    = (event_input_pin_i == pol);

    // timer 0 input clock: event edges, gated prescaler, or plain prescaler
    wire tick0 = ev_mode ? (ctrl[0].run && ev_edge)
               : func    ? (pre_tick0 && lvl_ok)
               :           pre_tick0;

    // underflow of each byte; timer 1 cascades from timer 0 in 16-bit mode
    wire uf0   = tick0 && (cnt[0] == pdt_pkg::RST_BYTE);
    wire tick1 = width ? uf0 : pre_tick1;
    wire uf1   = tick1 && (cnt[1] == pdt_pkg::RST_BYTE);

    // underflow that ends a one-shot sequence for timer 0
    wire end0  = width ? uf1 : uf0;

    // clock output source
    wire sel_uf = (width || mode.clock_out_channel_select) ? uf1 : uf0;

    // next run bits: a software write wins over the one-shot clear
    wire next_run0 = wr_ctrl0 ? wr_data_i[pdt_pkg::B_RUN]
                   : (end0 && !ctrl[0].repeat_sel) ? 1'b0
                   : ctrl[0].run;
    wire next_run1 = width ? 1'b0
                   : wr_ctrl1 ? wr_data_i[pdt_pkg::B_RUN]
                   : (uf1 && !ctrl[1].repeat_sel) ? 1'b0
                   : ctrl[1].run;

    // next counter values: preset beats underflow beats count
    wire [7:0] next_cnt0 = preset0 ? reload[0]
                         : uf0     ? reload[0]
                         : tick0   ? cnt[0] - 8'h01
                         :           cnt[0];
    wire [7:0] next_cnt1 = (preset1 || (width && preset0)) ? reload[1]
                         : uf1     ? reload[1]
                         : tick1   ? cnt[1] - 8'h01
                         :           cnt[1];

    // mode bits in register order; the packed struct lists them the other way round,
    // so a plain copy of the struct would put the width bit at the top
    wire [4:0] mode_rd = {mode.clock_out_channel_select, mode.function_select,
                          mode.input_polarity_select, mode.counter_mode_select,
                          mode.width_select};

    // read mux; preset strobes always read back as zero
    wire [7:0] rd_mux =
        (addr_i == pdt_pkg::OFF_CTRL_T0)   ? {3'b000, ctrl[0].ratio, ctrl[0].source_sel,
                                              ctrl[0].repeat_sel, ctrl[0].run} :
        (addr_i == pdt_pkg::OFF_CTRL_T1)   ? {3'b000, ctrl[1].ratio, ctrl[1].source_sel,
                                              ctrl[1].repeat_sel, ctrl[1].run} :
        (addr_i == pdt_pkg::OFF_MODE)      ? {3'b000, mode_rd} :
        (addr_i == pdt_pkg::OFF_RELOAD_T0) ? reload[0] :
        (addr_i == pdt_pkg::OFF_RELOAD_T1) ? reload[1] :
        (addr_i == pdt_pkg::OFF_COUNT_T0)  ? cnt[0] :
        (addr_i == pdt_pkg::OFF_COUNT_T1)  ? cnt[1] :
                                             pdt_pkg::RST_BYTE;

    // control registers; timer 1 fields other than run still store in 16-bit mode but steer nothing
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ctrl[0] <= pdt_pkg::RST_CTRL;
            ctrl[1] <= pdt_pkg::RST_CTRL;
            mode    <= pdt_pkg::RST_MODE;
        end else begin
            ctrl[0].run <= next_run0;
            ctrl[1].run <= next_run1;
            if (wr_ctrl0) begin
                ctrl[0].repeat_sel <= wr_data_i[pdt_pkg::B_REPEAT];
                ctrl[0].source_sel <= wr_data_i[pdt_pkg::B_SOURCE];
                ctrl[0].ratio      <= wr_data_i[pdt_pkg::B_RATIO +: 2];
            end
            if (wr_ctrl1) begin
                ctrl[1].repeat_sel <= wr_data_i[pdt_pkg::B_REPEAT];
                ctrl[1].source_sel <= wr_data_i[pdt_pkg::B_SOURCE];
                ctrl[1].ratio      <= wr_data_i[pdt_pkg::B_RATIO +: 2];
            end
            // each mode bit is taken from its own field position
            if (wr_mode) begin
                mode.width_select             <= wr_data_i[pdt_pkg::B_WIDTH];
                mode.counter_mode_select      <= wr_data_i[pdt_pkg::B_EVENT];
                mode.input_polarity_select    <= wr_data_i[pdt_pkg::B_POL];
                mode.function_select          <= wr_data_i[pdt_pkg::B_FUNC];
                mode.clock_out_channel_select <= wr_data_i[pdt_pkg::B_CLOCK_OUT_CHANNEL_SELECT];
            end
        end
    end

    // reload value registers
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            reload[0] <= pdt_pkg::RST_BYTE;
            reload[1] <= pdt_pkg::RST_BYTE;
        end else begin
            if (wr_rld0) reload[0] <= wr_data_i;
            if (wr_rld1) reload[1] <= wr_data_i;
        end
    end

    // down counters
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cnt[0] <= pdt_pkg::RST_BYTE;
            cnt[1] <= pdt_pkg::RST_BYTE;
        end else begin
            cnt[0] <= next_cnt0;
            cnt[1] <= next_cnt1;
        end
    end

    // prescalers keep their phase across a stop so a resume is not early
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pre[0] <= pdt_pkg::RST_PRE;
            pre[1] <= pdt_pkg::RST_PRE;
        end else begin
            if (feed0) pre[0] <= pre[0] + 6'h01;
            if (feed1) pre[1] <= pre[1] + 6'h01;
        end
    end

    // edge history of oscillators, reference and event level
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            slow_prev <= 1'b0;
            fast_prev <= 1'b0;
            ref_prev  <= 1'b0;
            ev_prev   <= 1'b0;
        end else begin
            slow_prev <= slow_oscillator_i;
            fast_prev <= fast_oscillator_i;
            ref_prev  <= noise_ref_i;
            ev_prev   <= ev_level;
        end
    end

    // noise rejecter: a changed level must survive two reference falling edges;
    // glitches shorter than about one reference period are dropped
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            filt   <= 1'b0;
            nr_cnt <= 2'b00;
        end else if (event_input_pin_i == filt) begin
            nr_cnt <= 2'b00;
        end else if (ref_fall) begin
            if (nr_cnt == pdt_pkg::NR_EDGES - 2'h1) begin
                filt   <= event_input_pin_i;
                nr_cnt <= 2'b00;
            end else begin
                nr_cnt <= nr_cnt + 2'h1;
            end
        end
    end

    // outputs, all registered
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rd_data_o                <= pdt_pkg::RST_BYTE;
            underflow_flag_t0_o      <= 1'b0;
            underflow_flag_t1_o      <= 1'b0;
            halved_underflow_out                     <= 1'b0;
            clock_out_pin_o          <= 1'b0;
            inverted_clock_out_pin_o <= 1'b1;
        end else begin
            rd_data_o                <= rd_en_i ? rd_mux : pdt_pkg::RST_BYTE;
            underflow_flag_t0_o      <= uf0 && !width;
            underflow_flag_t1_o      <= uf1;
            halved_underflow_out                     <= halved_underflow_out ^ sel_uf;
            clock_out_pin_o          <= halved_underflow_out ^ sel_uf;
            inverted_clock_out_pin_o <= ~(halved_underflow_out ^ sel_uf);
        end
    end

    // preset lands the reload value next cycle
    property p_preset;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        preset0 |=> (cnt[0] == $past(reload[0]));
    endproperty
    a_preset: assert property (p_preset) else $error("preset did not load reload value");

    // a stopped timer holds its count
    property p_hold;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (!ctrl[0].run && !preset0) |=> $stable(cnt[0]);
    endproperty
    a_hold: assert property (p_hold) else $error("stopped timer 0 changed count");

    // one-shot end clears run unless software rewrites it
    property p_oneshot;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (end0 && !ctrl[0].repeat_sel && !wr_ctrl0) |=>
            (!ctrl[0].run && (cnt[0] == $past(reload[0])));
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot did not stop");

    // repeat mode keeps running after underflow
    property p_repeat;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (uf0 && ctrl[0].repeat_sel && !wr_ctrl0) |=> ctrl[0].run && cnt[0] == $past(reload[0]);
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat mode lost run or reload");

    // timer 1 run stays low in 16-bit mode
    property p_run1_low;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        width |=> !ctrl[1].run;
    endproperty
    a_run1_low: assert property (p_run1_low) else $error("timer 1 run set in 16-bit mode");

    // no timer 0 flag in 16-bit mode
    property p_flag0;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ($past(width) && width) |-> !underflow_flag_t0_o;
    endproperty
    a_flag0: assert property (p_flag0) else $error("timer 0 flag in 16-bit mode");

    // clock output toggles exactly on the selected underflow
    property p_halved_underflow_out;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        sel_uf |=> (clock_out_pin_o != $past(clock_out_pin_o)) ##1 1'b1;
    endproperty
    a_halved_underflow_out: assert property (p_halved_underflow_out) else $error("clock output failed to toggle");

    // high byte only moves on low byte underflow or a timer 0 preset in 16-bit mode
    property p_cascade;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (width && !uf0 && !preset0) |=> $stable(cnt[1]);
    endproperty
    a_cascade: assert property (p_cascade) else $error("high byte moved without carry");

    // pulse width mode never counts at the wrong level
    property p_pulse;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (func && !ev_mode && !lvl_ok) |-> !tick0;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse mode counted at wrong level");

    // every timer 1 or 16-bit underflow shows as a flag pulse next cycle
    property p_flag1;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        uf1 |=> underflow_flag_t1_o;
    endproperty
    a_flag1: assert property (p_flag1) else $error("underflow gave no flag pulse");

    // a 16-bit preset loads the high byte as well
    property p_preset16;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (width && preset0) |=> (cnt[1] == $past(reload[1]));
    endproperty
    a_preset16: assert property (p_preset16) else $error("high byte missed preset");

    // the two clock output pins always stand opposite
    property p_clk_inv;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        1'b1 |-> (inverted_clock_out_pin_o != clock_out_pin_o);
    endproperty
    a_clk_inv: assert property (p_clk_inv) else $error("clock outputs not inverse");

    // a stopped timer feeds nothing into its prescaler
    property p_feed;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !run_eff0 |=> $stable(pre[0]);
    endproperty
    a_feed: assert property (p_feed) else $error("prescaler moved while stopped");

    // the filtered level only moves on a reference falling edge
    property p_rejecter;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !ref_fall |=> $stable(filt);
    endproperty
    a_rejecter: assert property (p_rejecter) else $error("filtered level moved off edge");

endmodule // pdt_timer

// [shared/pdt_pkg.sv]
// constants, field layout and carrier types of the dual programmable down timer
// assumes a plain 8-bit register port and one core clock; oscillators arrive as levels
package pdt_pkg;

    // register port, counter and prescaler widths
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W  = 8;
    localparam int unsigned PRE_W  = 6;

    // register offsets
    localparam logic [3:0] OFF_CTRL_T0   = 4'h0;
    localparam logic [3:0] OFF_CTRL_T1   = 4'h1;
    localparam logic [3:0] OFF_MODE      = 4'h2;
    localparam logic [3:0] OFF_RELOAD_T0 = 4'h3;
    localparam logic [3:0] OFF_RELOAD_T1 = 4'h4;
    localparam logic [3:0] OFF_COUNT_T0  = 4'h5;
    localparam logic [3:0] OFF_COUNT_T1  = 4'h6;

    // per-timer control register fields
    localparam int unsigned B_RUN    = 0;
    localparam int unsigned B_REPEAT = 1;
    localparam int unsigned B_SOURCE = 2;
    localparam int unsigned B_RATIO  = 3;
    localparam int unsigned B_PRESET = 5;

    // mode register fields
    localparam int unsigned B_WIDTH  = 0;
    localparam int unsigned B_EVENT  = 1;
    localparam int unsigned B_POL    = 2;
    localparam int unsigned B_FUNC   = 3;
    localparam int unsigned B_CLOCK_OUT_CHANNEL_SELECT  = 4;

    // prescaler masks for ratio codes 00, 01, 10, 11 (divide by 1, 4, 16, 64)
    localparam logic [5:0] PRE_MASK_1  = 6'h00;
    localparam logic [5:0] PRE_MASK_4  = 6'h03;
    localparam logic [5:0] PRE_MASK_16 = 6'h0F;
    localparam logic [5:0] PRE_MASK_64 = 6'h3F;

    // noise rejecter passes a level at this falling edge of the reference
    localparam logic [1:0] NR_EDGES = 2'h2;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] RST_PRE  = 6'h00;

    // timer control carrier
    typedef struct packed {
        logic       run;
        logic       repeat_sel;
        logic       source_sel;
        logic [1:0] ratio;
    } pdt_ctrl_s;

    // shared mode carrier
    typedef struct packed {
        logic width_select;
        logic counter_mode_select;
        logic input_polarity_select;
        logic function_select;
        logic clock_out_channel_select;
    } pdt_mode_s;

    localparam pdt_ctrl_s RST_CTRL = '{1'b0, 1'b0, 1'b0, 2'b00};
    localparam pdt_mode_s RST_MODE = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

endpackage

// [dv/pdt_src.sv]
// partner: source clocks, noise reference and the event pin
// assumes the bench asks for pin levels and keeps their hold times
`timescale 1ns/1ps
module pdt_src (
    input  wire logic clk_i,   // core clock
    input  wire logic level_i, // pin level asked for by the bench
    output logic      slow_o,  // slow source clock
    output logic      fast_o,  // fast source clock, rises every 4 cycles
    output logic      ref_o,   // noise reference, 32-cycle period
    output logic      pin_o    // event input pin
);
    logic [4:0] div   = 5'h00; // free divider behind every clock
    logic       pin_q = 1'b1;  // pin idles high
    // fast source runs from time zero, so it is settled before any start
    always_ff @(posedge clk_i) begin
        div   <= div + 5'h01;
        pin_q <= level_i;
    end
    assign slow_o = div[3];
    assign fast_o = div[1];
    assign ref_o  = div[4];
    assign pin_o  = pin_q;
endmodule // pdt_src

// [dv/dual_programmable_down_timer_test.sv]
// self-checking bench: register port, event pin edges, flag and clock out
// assumes pdt_pkg is compiled first and pdt_src drives the pin side
`timescale 1ns/1ps
module dual_programmable_down_timer_test;
    logic        core_clk_i = 1'b0;
    logic        rst_n_i    = 1'b0;
    logic [3:0]  addr_i     = 4'h0;
    logic [7:0]  wr_data_i  = 8'h00;
    logic        wr_en_i    = 1'b0;
    logic        rd_en_i    = 1'b0;
    logic        level      = 1'b1; // pin level asked of the partner
    logic        slow, fast, nref, pin, uf0, uf1, ck, ckn;
    logic [7:0]  rd_data_o;
    logic [7:0]  exp_q[$];          // expected read data, oldest first
    logic        rd_seen    = 1'b0; // a read was taken last edge
    int          n_errors   = 0;
    int          checks     = 0;
    int          n_uf0      = 0;
    int          n_uf1      = 0;
    logic [31:0] lfsr       = 32'h7d53_be6f;
    logic [7:0]  rl;                // random reload value
    // 10 MHz core clock
    initial begin
        forever #50 core_clk_i = ~core_clk_i;
    end
    pdt_timer i_pdt_timer (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .slow_oscillator_i(slow),
        .fast_oscillator_i(fast), .noise_ref_i(nref), .event_input_pin_i(pin),
        .rd_data_o(rd_data_o), .underflow_flag_t0_o(uf0), .underflow_flag_t1_o(uf1),
        .clock_out_pin_o(ck), .inverted_clock_out_pin_o(ckn));
    pdt_src i_pdt_src (.clk_i(core_clk_i), .level_i(level), .slow_o(slow), .fast_o(fast),
        .ref_o(nref), .pin_o(pin));
    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // next state of the stimulus shift register
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus cycle; idle cycles keep each strobe a single cycle long
    task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        wr_en_i   <= w;
        rd_en_i   <= r;
        addr_i    <= a;
        wr_data_i <= d;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
    endtask
    // n low pulses on the pin, each level held h+1 cycles
    task automatic pulses(input int n, input int h);
        repeat (2 * n) begin
            @(posedge core_clk_i);
            level <= ~level;
            repeat (h) @(posedge core_clk_i);
        end
    endtask
    // read data stand only in the cycle after the strobe
    always @(posedge core_clk_i) begin
        if (rd_seen) cmp(rd_data_o, exp_q.pop_front());
        rd_seen <= rd_en_i;
        n_uf0   += int'(uf0 === 1'b1);
        n_uf1   += int'(uf1 === 1'b1);
    end
    // hang guard
    initial begin
        repeat (60000) @(posedge core_clk_i);
        n_errors++;
        $display("mismatch at %0t: run did not finish", $time);
        close_out();
    end
    initial begin
        repeat (16) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        // reset values, unmapped places read zero
        for (int a = 0; a < 16; a++) rd(4'(a), 8'h00);
        lfsr = lfsr_next(lfsr);
        rl = lfsr[7:0] | 8'h08;
        wr(pdt_pkg::OFF_RELOAD_T0, rl);
        wr(pdt_pkg::OFF_CTRL_T0, 8'h20);
        rd(pdt_pkg::OFF_COUNT_T0, rl);
        rd(pdt_pkg::OFF_CTRL_T0, 8'h00);
        wr(pdt_pkg::OFF_COUNT_T0, 8'h55);
        rd(pdt_pkg::OFF_COUNT_T0, rl);
        // event mode, rising edges, continuous
        wr(pdt_pkg::OFF_MODE, 8'h06);
        wr(pdt_pkg::OFF_CTRL_T0, 8'h03);
        pulses(3, 4);
        rd(pdt_pkg::OFF_COUNT_T0, rl - 8'h03);
        wr(pdt_pkg::OFF_CTRL_T0, 8'h02);
        pulses(2, 4);
        rd(pdt_pkg::OFF_COUNT_T0, rl - 8'h03);
        rd(pdt_pkg::OFF_COUNT_T1, 8'h00);
        wr(pdt_pkg::OFF_RELOAD_T0, 8'h02);
        wr(pdt_pkg::OFF_CTRL_T0, 8'h23);
        pulses(9, 4);
        rd(pdt_pkg::OFF_COUNT_T0, 8'h02);
        rd(pdt_pkg::OFF_CTRL_T0, 8'h03);
        cmp({6'h00, ckn, ck}, 8'h01);
        // falling edges, then one-shot
        wr(pdt_pkg::OFF_MODE, 8'h02);
        pulses(1, 4);
        rd(pdt_pkg::OFF_COUNT_T0, 8'h01);
        wr(pdt_pkg::OFF_CTRL_T0, 8'h21);
        pulses(3, 4);
        rd(pdt_pkg::OFF_CTRL_T0, 8'h00);
        pulses(2, 4);
        rd(pdt_pkg::OFF_COUNT_T0, 8'h02);
        wr(pdt_pkg::OFF_CTRL_T0, 8'h01);
        pulses(1, 4);
        rd(pdt_pkg::OFF_COUNT_T0, 8'h01);
        // 16-bit event counter, timer 1 run bit refused
        wr(pdt_pkg::OFF_MODE, 8'h07);
        wr(pdt_pkg::OFF_RELOAD_T0, 8'h01);
        wr(pdt_pkg::OFF_RELOAD_T1, 8'h01);
        wr(pdt_pkg::OFF_CTRL_T1, 8'h01);
        rd(pdt_pkg::OFF_CTRL_T1, 8'h00);
        wr(pdt_pkg::OFF_CTRL_T0, 8'h23);
        pulses(2, 4);
        rd(pdt_pkg::OFF_COUNT_T0, 8'h01);
        rd(pdt_pkg::OFF_COUNT_T1, 8'h00);
        pulses(2, 4);
        rd(pdt_pkg::OFF_COUNT_T1, 8'h01);
        cmp({6'h00, ckn, ck}, 8'h01);
        cmp(8'(n_uf0), 8'h04);
        cmp(8'(n_uf1), 8'h01);
        // pulse width mode counts only while the pin is low
        wr(pdt_pkg::OFF_MODE, 8'h08);
        wr(pdt_pkg::OFF_RELOAD_T0, rl);
        wr(pdt_pkg::OFF_CTRL_T0, 8'h27);
        repeat (100) @(posedge core_clk_i);
        rd(pdt_pkg::OFF_COUNT_T0, rl);
        // pin low for 40 sampled edges holds exactly 10 fast source rises
        pulses(1, 39);
        rd(pdt_pkg::OFF_COUNT_T0, rl - 8'h0a);
        // noise rejecter: long levels pass, a glitch does not
        wr(pdt_pkg::OFF_MODE, 8'h0e);
        wr(pdt_pkg::OFF_CTRL_T0, 8'h23);
        pulses(2, 80);
        pulses(1, 2);
        repeat (80) @(posedge core_clk_i);
        rd(pdt_pkg::OFF_COUNT_T0, rl - 8'h02);
        // timer 1, slow source divided by 4: 128 running edges give 8 rises, 2 ticks
        wr(pdt_pkg::OFF_RELOAD_T1, rl);
        wr(pdt_pkg::OFF_CTRL_T1, 8'h2b);
        repeat (126) @(posedge core_clk_i);
        wr(pdt_pkg::OFF_CTRL_T1, 8'h0a);
        rd(pdt_pkg::OFF_COUNT_T1, rl - 8'h02);
        repeat (4) @(posedge core_clk_i);
        close_out();
    end
endmodule // dual_programmable_down_timer_test
